// ===== hw/ext_reset_filter.sv
/*
 * external reset pin conditioner: pull-up, three-stage synchroniser, hold timer.
 * assumes the pin is asynchronous to pclk; driven flag is low when nobody drives the pin.
 */
`timescale 1ns/1ps
module ext_reset_filter
	import idle_pkg::*;
#(
	parameter int HOLD_CYCLES = RESET_HOLD_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic pin_n,
	input  wire logic pin_driven,
	output logic      rst_active_r,
	output logic      short_pulse_r
);

	// ************************************************
	// pull-up and synchroniser
	// ************************************************
	logic                         pin_level;
	logic [SYNC_STAGES-1:0]       sync_r;
	logic [HOLD_CNT_W-1:0]        hold_r;

	assign pin_level = pin_driven ? pin_n : 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_r <= '1;
		end else if (ce) begin
			sync_r <= {sync_r[SYNC_STAGES-2:0], pin_level};
		end
	end

	// ************************************************
	// debounce on stages two and three
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_active_r <= 1'b0;
		end else if (ce && (sync_r[1] == sync_r[2])) begin
			rst_active_r <= ~sync_r[2];
		end
	end

	// ************************************************
	// low-time check
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r        <= '0;
			short_pulse_r <= 1'b0;
		end else if (ce) begin
			if (rst_active_r) begin
				if (hold_r != HOLD_CNT_W'(HOLD_CYCLES)) begin
					hold_r <= hold_r + 1'b1;
				end
			end else if (hold_r != '0) begin
				short_pulse_r <= (hold_r != HOLD_CNT_W'(HOLD_CYCLES));
				hold_r        <= '0;
			end
		end
	end

endmodule : ext_reset_filter

// ===== hw/idle_mode_ctrl.sv
/*
 * idle power mode controller with APB registers, wake timer and external reset input.
 * assumes an APB master on pclk and power switches that obey the enable outputs.
 */
`timescale 1ns/1ps
module idle_mode_ctrl
	import idle_pkg::*;
#(
	parameter int HOLD_CYCLES = RESET_HOLD_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              ext_reset_pin_n,
	input  wire logic              ext_reset_pin_driven,
	output logic                   core_run,
	output logic                   osc_enable,
	output logic                   wdog_enable,
	output logic                   wake_timer_enable,
	output logic                   low_voltage_detector_power,
	output logic                   brownout_reset_circuit_power,
	output logic                   periph_power,
	output logic      [7:0]        multi_input_wakeup_enable,
	output logic                   chip_reset
);

	// ************************************************
	// declarations
	// ************************************************
	pm_state_t             state_r;
	logic [WAKE_CNT_W-1:0] wake_cnt_r;
	logic                  wake_ovf_r;
	logic [7:0]            wakeup_en_r;
	logic [7:0]            mode_clr_r;
	logic                  ready_r;
	logic                  err_r;
	logic [DATA_W-1:0]     rdata_r;
	logic                  core_run_r;
	logic                  aon_r;
	logic                  sleep_pwr_r;
	logic                  chip_reset_r;
	logic                  ext_rst;
	logic                  short_rst;
	logic                  access;
	logic                  wr_acc;
	logic                  idle_req;
	logic                  wake;
	reg_sel_t              sel;

	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		if (a == ADDR_POWER_MODE) begin
			decode = SEL_POWER_MODE;
		end else if (a == ADDR_WAKEUP_EN) begin
			decode = SEL_WAKEUP_EN;
		end else if (a == ADDR_MODE_CLR) begin
			decode = SEL_MODE_CLR;
		end else if (a == ADDR_STATUS) begin
			decode = SEL_STATUS;
		end else begin
			decode = SEL_NONE;
		end
	endfunction : decode

	// ************************************************
	// external reset conditioner
	// ************************************************
	ext_reset_filter #(
		.HOLD_CYCLES   (HOLD_CYCLES)
	) i_ext_reset_filter (
		.pclk          (pclk),
		.presetn       (presetn),
		.ce            (ce),
		.pin_n         (ext_reset_pin_n),
		.pin_driven    (ext_reset_pin_driven),
		.rst_active_r  (ext_rst),
		.short_pulse_r (short_rst)
	);

	// ************************************************
	// APB handshake
	// ************************************************
	assign sel      = decode(paddr);
	assign access   = psel && penable && ready_r;
	assign wr_acc   = access && pwrite && !ext_rst;
	assign idle_req = wr_acc && (sel == SEL_POWER_MODE) && pwdata[IDLE_EN_BIT];
	assign wake     = (state_r == PM_IDLE) && wake_ovf_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= '0;
		end else if (ce) begin
			ready_r <= psel && penable && !ready_r;
			err_r   <= psel && penable && !ready_r && (decode(paddr) == SEL_NONE);
			rdata_r <= '0;
			if (psel && penable && !ready_r && !pwrite) begin
				if (decode(paddr) == SEL_WAKEUP_EN) begin
					rdata_r <= {{(DATA_W-BYTE_W){1'b0}}, wakeup_en_r};
				end else if (decode(paddr) == SEL_MODE_CLR) begin
					rdata_r <= {{(DATA_W-BYTE_W){1'b0}}, mode_clr_r};
				end else if (decode(paddr) == SEL_STATUS) begin
					rdata_r[ST_IDLE_BIT]     <= (state_r == PM_IDLE);
					rdata_r[ST_EXTRST_BIT]   <= ext_rst;
					rdata_r[ST_SHORTRST_BIT] <= short_rst;
				end
				// power mode register reads zero: enable bits are write-only
			end
		end
	end

	// ************************************************
	// wake timer, free running in run and idle, held at zero while external reset is active
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cnt_r <= '0;
			wake_ovf_r <= 1'b0;
		end else if (ce) begin
			if (ext_rst) begin
				wake_cnt_r <= '0;
				wake_ovf_r <= 1'b0;
			end else begin
				wake_cnt_r <= wake_cnt_r + 1'b1;
				wake_ovf_r <= (wake_cnt_r == '1);
			end
		end
	end

	// ************************************************
	// power mode state
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= PM_RUN;
		end else if (ce) begin
			if (ext_rst) begin
				state_r <= PM_RUN;
			end else begin
				case (state_r)
					PM_RUN: begin
						if (idle_req) begin
							state_r <= PM_IDLE;
						end
					end
					PM_IDLE: begin
						if (wake) begin
							state_r <= PM_RUN;
						end
					end
					default: begin
						state_r <= PM_RUN;
					end
				endcase
			end
		end
	end

	// ************************************************
	// power and clock enables
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_run_r  <= 1'b1;
			aon_r       <= 1'b1;
			sleep_pwr_r <= 1'b1;
		end else if (ce) begin
			aon_r <= 1'b1;
			if (ext_rst || wake) begin
				core_run_r  <= 1'b1;
				sleep_pwr_r <= 1'b1;
			end else if (idle_req && (state_r == PM_RUN)) begin
				core_run_r  <= 1'b0;
				sleep_pwr_r <= 1'b0;
			end
		end
	end

	// ************************************************
	// wakeup enable and power mode clear registers
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wakeup_en_r <= WAKEUP_EN_RST;
		end else if (ce) begin
			if (ext_rst) begin
				wakeup_en_r <= WAKEUP_EN_RST;
			end else if (wr_acc && (sel == SEL_WAKEUP_EN)) begin
				wakeup_en_r <= pwdata[BYTE_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_clr_r <= MODE_CLR_RST;
		end else if (ce) begin
			if (ext_rst) begin
				mode_clr_r <= MODE_CLR_RST;
			end else begin
				if (wr_acc && (sel == SEL_MODE_CLR)) begin
					mode_clr_r <= pwdata[BYTE_W-1:0];
				end
				if (wake) begin
					mode_clr_r[CLR_EXIT_BIT] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_reset_r <= 1'b0;
		end else if (ce) begin
			chip_reset_r <= ext_rst;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign prdata                       = rdata_r;
	assign pready                       = ready_r;
	assign pslverr                      = err_r;
	assign core_run                     = core_run_r;
	assign osc_enable                   = aon_r;
	assign wdog_enable                  = aon_r;
	assign wake_timer_enable            = aon_r;
	assign low_voltage_detector_power   = sleep_pwr_r;
	assign brownout_reset_circuit_power = sleep_pwr_r;
	assign periph_power                 = sleep_pwr_r;
	assign multi_input_wakeup_enable    = wakeup_en_r;
	assign chip_reset                   = chip_reset_r;

endmodule : idle_mode_ctrl

// ===== hw/idle_pkg.sv
/*
 * constants for the idle mode controller and its external reset filter.
 * assumes a 200 MHz pclk and a 32-bit APB register port.
 */
// Notes on behaviour
// - an undriven external reset pin reads as high, so it counts as inactive.
// - the idle enable bit is write-only, reads as zero and clears itself when idle ends.
// - in idle the oscillator, the watchdog and the wake timer keep running.
// - in idle the low-voltage detector, the brown-out reset circuit and other systems are powered down.
// - idle ends on the wake timer overflow, which comes every 8192 clock cycles.
// - once the wake is triggered the core runs again on the next clock, with no start-up delay.
// - the idle enable bit is bit 1 of the power mode register, halt enable is bit 0, bits 7 to 2 are undefined.
package idle_pkg;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [7:0]  ADDR_POWER_MODE  = 8'h00;
	localparam logic [7:0]  ADDR_WAKEUP_EN   = 8'h04;
	localparam logic [7:0]  ADDR_MODE_CLR    = 8'h08;
	localparam logic [7:0]  ADDR_STATUS      = 8'h0c;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 32;
	localparam int          BYTE_W           = 8;

	// ************************************************
	// fields and reset values
	// ************************************************
	localparam int          HALT_EN_BIT      = 0;
	localparam int          IDLE_EN_BIT      = 1;
	localparam int          CLR_EXIT_BIT     = 0;
	localparam int          ST_IDLE_BIT      = 0;
	localparam int          ST_EXTRST_BIT    = 1;
	localparam int          ST_SHORTRST_BIT  = 2;
	localparam logic [7:0]  WAKEUP_EN_RST    = 8'h00;
	localparam logic [7:0]  MODE_CLR_RST     = 8'h00;

	// ************************************************
	// timing
	// ************************************************
	localparam int          CLK_MHZ          = 200;
	localparam int          RESET_HOLD_MS    = 2;
	localparam int          RESET_HOLD_CYC   = RESET_HOLD_MS * CLK_MHZ * 1000;
	localparam int          HOLD_CNT_W       = 20;
	localparam int          WAKE_PERIOD      = 8192;
	localparam int          WAKE_CNT_W       = $clog2(WAKE_PERIOD);
	localparam int          SYNC_STAGES      = 3;

	typedef enum logic [2:0] {
		SEL_POWER_MODE,
		SEL_WAKEUP_EN,
		SEL_MODE_CLR,
		SEL_STATUS,
		SEL_NONE
	} reg_sel_t;

	typedef enum logic {
		PM_RUN,
		PM_IDLE
	} pm_state_t;

endpackage : idle_pkg

// ===== test/idle_mode_ctrl_sva.sv
/*
 * concurrent checks on the idle mode controller ports.
 * assumes ce held high and HOLD_CYCLES irrelevant to these relations.
 */
`timescale 1ns/1ps
module idle_mode_ctrl_sva
	import idle_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              ext_reset_pin_driven,
	input wire logic              core_run,
	input wire logic              osc_enable,
	input wire logic              wdog_enable,
	input wire logic              wake_timer_enable,
	input wire logic              low_voltage_detector_power,
	input wire logic              brownout_reset_circuit_power,
	input wire logic              periph_power,
	input wire logic              chip_reset
);
	// ****
	// helpers
	// ****
	logic        acc;
	logic        idle_wr;
	logic [13:0] idle_cnt_r;
	assign acc = psel && penable && pready;
	assign idle_wr = acc && pwrite && paddr == ADDR_POWER_MODE && pwdata[IDLE_EN_BIT] && !chip_reset;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_cnt_r <= 14'h0;
		else if (core_run)
			idle_cnt_r <= 14'h0;
		else
			idle_cnt_r <= idle_cnt_r + 14'h1;
	end
	// ****
	// checks
	// ****
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_keep_clocks: assert property (osc_enable && wdog_enable && wake_timer_enable)
		else $error("clock enables dropped");
	a_idle_power_off: assert property (!core_run |-> !low_voltage_detector_power
		&& !brownout_reset_circuit_power && !periph_power) else $error("power on in idle");
	a_idle_entry: assert property (core_run && idle_wr |=> !core_run)
		else $error("idle not entered");
	a_run_stays: assert property (core_run && !idle_wr |=> core_run)
		else $error("left run without idle write");
	a_wake_bound: assert property (idle_cnt_r <= 14'h2000)
		else $error("idle longer than wake period");
	a_pm_reads_zero: assert property (acc && !pwrite && paddr == ADDR_POWER_MODE |-> prdata == 32'h0)
		else $error("power mode read not zero");
	a_wake_power: assert property ($rose(core_run) |-> low_voltage_detector_power
		&& brownout_reset_circuit_power && periph_power) else $error("power late at wake");
	a_undriven_idle: assert property (!ext_reset_pin_driven [*8] |-> !chip_reset)
		else $error("undriven pin resets");
endmodule : idle_mode_ctrl_sva

// ===== test/idle_mode_ctrl_tb.sv
/*
 * self-checking bench for the idle mode controller over APB.
 * assumes the hand-over timing of the design; short hold count of 50.
 */
`timescale 1ns/1ps
module idle_mode_ctrl_tb;
	import idle_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, chip_reset;
	logic        ext_reset_pin_n, ext_reset_pin_driven, core_run, osc_enable, wdog_enable, wake_timer_enable;
	logic        low_voltage_detector_power, brownout_reset_circuit_power, periph_power;
	logic [7:0]  paddr, multi_input_wakeup_enable;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0]  outs;
	int          fail_count, check_count, n;
	assign outs = {core_run, osc_enable, wdog_enable, wake_timer_enable,
		low_voltage_detector_power, brownout_reset_circuit_power, periph_power};
	idle_mode_ctrl #(.HOLD_CYCLES(50)) i_idle_mode_ctrl (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .ext_reset_pin_n, .ext_reset_pin_driven, .core_run, .osc_enable,
		.wdog_enable, .wake_timer_enable, .low_voltage_detector_power, .brownout_reset_circuit_power,
		.periph_power, .multi_input_wakeup_enable, .chip_reset);
	// ****
	// tasks
	// ****
	task summarize();
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			fail_count++;
			summarize();
		end
	endtask : apb
	task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(name, exp, rd);
	endtask : rdchk
	// ****
	// stimulus
	// ****
	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#500000;
		fail_count++;
		summarize();
	end
	initial begin
		presetn = 1'h0;
		ce = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		ext_reset_pin_n = 1'h1;
		ext_reset_pin_driven = 1'h1;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		#1 chk("outs", 32'h7f, {25'h0, outs});
		apb(1'h1, ADDR_WAKEUP_EN, 32'ha5);
		rdchk("wakeup_en", ADDR_WAKEUP_EN, 32'ha5);
		chk("mi_wakeup", 32'ha5, {24'h0, multi_input_wakeup_enable});
		apb(1'h1, ADDR_WAKEUP_EN, 32'h0);
		apb(1'h1, ADDR_POWER_MODE, 32'h1);
		#1 chk("halt_only", 32'h1, {31'h0, core_run});
		rdchk("power_mode", ADDR_POWER_MODE, 32'h0);
		apb(1'h0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'h1, ADDR_POWER_MODE, 32'h2);
		#1 chk("idle_outs", 32'h38, {25'h0, outs});
		rdchk("status_idle", ADDR_STATUS, 32'h1);
		n = 0;
		while (core_run !== 1'h1 && n < 8300) begin
			@(posedge pclk);
			#1 n++;
		end
		chk("wake_time", 32'h1, {31'h0, n <= 8192});
		chk("wake_outs", 32'h7f, {25'h0, outs});
		rdchk("mode_clr_set", ADDR_MODE_CLR, 32'h1);
		rdchk("status_run", ADDR_STATUS, 32'h0);
		apb(1'h1, ADDR_MODE_CLR, 32'h0);
		rdchk("mode_clr_clear", ADDR_MODE_CLR, 32'h0);
		repeat (8300) @(posedge pclk);
		#1 chk("run_no_wake", 32'h7f, {25'h0, outs});
		@(posedge pclk);
		ce <= 1'h0;
		ext_reset_pin_n <= 1'h0;
		repeat (8) @(posedge pclk);
		#1 chk("ce_freeze", 32'h0, {31'h0, chip_reset});
		@(posedge pclk);
		ce <= 1'h1;
		repeat (8) @(posedge pclk);
		#1 chk("chip_reset", 32'h1, {31'h0, chip_reset});
		apb(1'h1, ADDR_WAKEUP_EN, 32'h33);
		rdchk("wr_in_reset", ADDR_WAKEUP_EN, 32'h0);
		ext_reset_pin_driven <= 1'h0;
		repeat (8) @(posedge pclk);
		#1 chk("undriven", 32'h0, {31'h0, chip_reset});
		rdchk("short_rst", ADDR_STATUS, 32'h4);
		@(posedge pclk);
		ext_reset_pin_driven <= 1'h1;
		repeat (100) @(posedge pclk);
		ext_reset_pin_n <= 1'h1;
		repeat (8) @(posedge pclk);
		rdchk("long_rst", ADDR_STATUS, 32'h0);
		summarize();
	end
endmodule : idle_mode_ctrl_tb
bind idle_mode_ctrl idle_mode_ctrl_sva i_idle_mode_ctrl_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .ext_reset_pin_driven, .core_run, .osc_enable, .wdog_enable, .wake_timer_enable,
	.low_voltage_detector_power, .brownout_reset_circuit_power, .periph_power, .chip_reset);
